// [hdl/fmi_regs.vh]
/*
 * Constants of the flash map and information-area overlay block.
 * Assumes byte-wide memory requests with 16-bit addresses.
 */
`ifndef FMI_REGS_VH
`define FMI_REGS_VH

// array geometry
`define FMI_PAGE_LSB 9
`define FMI_ROW_LSB 6
`define FMI_PAGE_LAST 9'h1FF
`define FMI_BIG_LAST 13'h1FFF
`define FMI_SMALL_LAST 13'h0FFF
`define FMI_ERASED 8'hFF

// option bytes at the bottom of program memory
`define FMI_OPT_LO 13'h0000
`define FMI_OPT_HI 13'h0001

// information area window FE00-FE7F
`define FMI_INFO_PAGE 9'h1FC
`define FMI_OPT_LAST 7'h3F
`define FMI_TRIM_LAST 7'h07
`define FMI_PART_FIRST 7'h40
`define FMI_PART_LAST 7'h53
`define FMI_RSV_FIRST 7'h54
`define FMI_RSV_LAST 7'h5F
`define FMI_CAL_FIRST 7'h60
`define FMI_PART_PAD 8'h0F
`define FMI_RSV_VALUE 8'h00
`define FMI_OPT_VALUE 8'hFF
`define FMI_OPT_WRBLK_VALUE 8'hFE
`define FMI_OPT_WRBLK_BIT 0
`define FMI_CAL_VALUE 8'h80

// page select register
`define FMI_PGSEL_INFO_BIT 7
`define FMI_PGSEL_RESET 8'h00
`define FMI_PROT_RESET 8'h00

// control commands
`define FMI_CMD_UNLOCK1 8'h73
`define FMI_CMD_UNLOCK2 8'h8C
`define FMI_CMD_PAGE_ERASE 8'h95
`define FMI_CMD_SECT_PROT 8'h5E
`define FMI_CMD_MASS_ERASE 8'h63

`endif

// [hdl/fmi_info_rom.v]
/*
 * Read-only contents of the 128-byte information area, two read ports.
 * Assumes the caller registers whatever it presents outside.
 */
`default_nettype none
`include "fmi_regs.vh"

module fmi_info_rom (
    // main read port
    input wire [6:0] rd_addr,
    output wire [7:0] rd_data,
    // trim shadow load port
    input wire [6:0] trim_addr,
    output wire [7:0] trim_data,
    // factory write-block option
    output wire wr_block
);

    // part identifier, value arbitrary, padded to twenty characters
    localparam [159:0] PART_ID = {"FMI-DEMO-ID", {9{`FMI_PART_PAD}}};

    // first option byte, held apart so its write-block bit can be picked
    wire [7:0] opt_first;

    function [7:0] info_byte;
        input [6:0] a;
        reg [6:0] k;
        begin
            k = a - `FMI_PART_FIRST;
            if (a == 7'h00) begin
                info_byte = `FMI_OPT_WRBLK_VALUE;
            end else if (a <= `FMI_OPT_LAST) begin
                info_byte = `FMI_OPT_VALUE;
            end else if (a <= `FMI_PART_LAST) begin
                info_byte = PART_ID[159 - 8 * k -: 8];
            end else if (a <= `FMI_RSV_LAST) begin
                info_byte = `FMI_RSV_VALUE;
            end else begin
                info_byte = `FMI_CAL_VALUE;
            end
        end
    endfunction

    assign rd_data = info_byte(rd_addr);
    assign trim_data = info_byte(trim_addr);
    assign opt_first = info_byte(7'h00);
    assign wr_block = ~opt_first[`FMI_OPT_WRBLK_BIT];

endmodule
`default_nettype wire

// [hdl/fmi_flash_map.v]
/*
 * Flash program memory array, page/sector protection, unlock sequencing
 * and the read-only information-area overlay at FE00-FE7F.
 * Assumes requests from core and debugger are synchronous to ref_clk
 * and that the size strap is stable when reset is released.
 */
`default_nettype none
`include "fmi_regs.vh"

module fmi_flash_map (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // size strap, high selects the 8 KB variant
    input wire big_variant,
    // memory request port
    input wire [15:0] mem_addr,
    input wire mem_rd,
    input wire mem_wr,
    input wire [7:0] mem_wdata,
    input wire dbg_access,
    output reg [7:0] mem_rdata,
    output reg mem_rvalid,
    output wire mem_busy,
    // controller register writes
    input wire ctl_wr,
    input wire pgsel_wr,
    input wire [7:0] reg_wdata,
    // controller status
    output reg [7:0] pgsel_value,
    output reg [7:0] sect_protect,
    output wire unlocked,
    output reg [2:0] erase_row,
    // trim holding registers
    input wire [2:0] trim_sel,
    output reg [7:0] trim_rdata,
    // option outputs
    output reg [15:0] option_bits,
    output reg data_wr_block
);

    localparam [2:0] ST_LOCK = 3'd0;
    localparam [2:0] ST_UNLK1 = 3'd1;
    localparam [2:0] ST_UNLK2 = 3'd2;
    localparam [2:0] ST_OPEN = 3'd3;
    localparam [2:0] ST_ERASE = 3'd4;
    localparam [2:0] ST_PROT = 3'd5;
    localparam [2:0] ST_MASS = 3'd6;

    reg [7:0] mem [0:8191];
    reg [7:0] trim_hold [0:7];

    reg [2:0] state;
    reg [2:0] next_state;
    reg [12:0] erase_cnt;
    reg big_q;
    reg strap_done;
    reg [3:0] trim_load;

    wire info_en;
    wire info_hit;
    wire trim_hit;
    wire [12:0] prog_idx;
    wire [3:0] req_page;
    wire [3:0] act_page;
    wire [2:0] req_sect;
    wire [2:0] act_sect;
    wire [12:0] size_last;
    wire [7:0] rom_data;
    wire [7:0] rom_trim;
    wire rom_wr_block;
    wire byte_wr;
    wire erase_end;

    reg mem_we;
    reg [12:0] mem_widx;
    reg [7:0] mem_wval;

    ////////////////////////////////////////////////////////////////////
    // address decode

    assign info_en = pgsel_value[`FMI_PGSEL_INFO_BIT];
    assign info_hit = info_en &&
        (mem_addr[15:7] == `FMI_INFO_PAGE);
    assign trim_hit = info_hit && (mem_addr[6:0] <= `FMI_TRIM_LAST);
    assign prog_idx = big_q ? mem_addr[12:0] :
        {1'b0, mem_addr[11:0]};
    assign size_last = big_q ? `FMI_BIG_LAST : `FMI_SMALL_LAST;
    assign req_page = big_q ? mem_addr[12:9] :
        {1'b0, mem_addr[11:9]};
    assign act_page = big_q ? pgsel_value[3:0] :
        {1'b0, pgsel_value[2:0]};
    assign req_sect = big_q ? mem_addr[12:10] : mem_addr[11:9];
    assign act_sect = big_q ? pgsel_value[3:1] : pgsel_value[2:0];

    assign mem_busy = (state == ST_ERASE) || (state == ST_MASS);
    assign unlocked = (state == ST_OPEN);
    assign erase_end = (state == ST_MASS) ? (erase_cnt == size_last) :
        (erase_cnt[8:0] == `FMI_PAGE_LAST);

    // byte program: only inside the active page of an open sector
    assign byte_wr = mem_wr && (state == ST_OPEN) && !info_hit &&
        (req_page == act_page) && !sect_protect[req_sect];

    fmi_info_rom u_rom (
        .rd_addr(mem_addr[6:0]),
        .rd_data(rom_data),
        .trim_addr({4'b0000, trim_load[2:0]}),
        .trim_data(rom_trim),
        .wr_block(rom_wr_block)
    );

    ////////////////////////////////////////////////////////////////////
    // size strap, caught once after reset release

    always @(posedge ref_clk) begin
        if (!rstn) begin
            big_q <= 1'b0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            big_q <= big_variant;
            strap_done <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // controller sequencing

    always @* begin
        next_state = state;
        case (state)
            ST_LOCK: begin
                if (ctl_wr && reg_wdata == `FMI_CMD_UNLOCK1) begin
                    next_state = ST_UNLK1;
                end else if (ctl_wr && reg_wdata == `FMI_CMD_SECT_PROT) begin
                    next_state = ST_PROT;
                end
            end
            ST_UNLK1: begin
                if (ctl_wr) begin
                    next_state = (reg_wdata == `FMI_CMD_UNLOCK2) ?
                        ST_UNLK2 : ST_LOCK;
                end
            end
            ST_UNLK2: begin
                if (ctl_wr) begin
                    next_state = ST_LOCK;
                end else if (pgsel_wr) begin
                    next_state = (reg_wdata == pgsel_value) ?
                        ST_OPEN : ST_LOCK;
                end
            end
            ST_OPEN: begin
                if (ctl_wr && reg_wdata == `FMI_CMD_PAGE_ERASE &&
                        !sect_protect[act_sect]) begin
                    next_state = ST_ERASE;
                end else if (ctl_wr && dbg_access &&
                        reg_wdata == `FMI_CMD_MASS_ERASE) begin
                    next_state = ST_MASS;
                end else if (ctl_wr) begin
                    next_state = ST_LOCK;
                end
            end
            ST_ERASE: begin
                if (erase_end) begin
                    next_state = ST_OPEN;
                end
            end
            ST_MASS: begin
                if (erase_end) begin
                    next_state = ST_OPEN;
                end
            end
            ST_PROT: begin
                if (pgsel_wr || ctl_wr) begin
                    next_state = ST_LOCK;
                end
            end
            default: begin
                next_state = ST_LOCK;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            state <= ST_LOCK;
            erase_cnt <= 13'h0000;
            erase_row <= 3'b000;
        end else begin
            state <= next_state;
            if (mem_busy && !erase_end) begin
                erase_cnt <= erase_cnt + 13'h0001;
            end else begin
                erase_cnt <= 13'h0000;
            end
            if (mem_busy) begin
                erase_row <= erase_cnt[8:6];
            end
        end
    end

    // page select doubles as sector protect after the protect command
    always @(posedge ref_clk) begin
        if (!rstn) begin
            pgsel_value <= `FMI_PGSEL_RESET;
            sect_protect <= `FMI_PROT_RESET;
        end else if (pgsel_wr && state == ST_PROT) begin
            sect_protect <= sect_protect | reg_wdata;
        end else if (pgsel_wr && !mem_busy) begin
            pgsel_value <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // array write port: erase fill or byte program

    always @* begin
        mem_we = 1'b0;
        mem_widx = prog_idx;
        mem_wval = mem_wdata;
        if (state == ST_ERASE) begin
            mem_we = 1'b1;
            mem_widx = {act_page, erase_cnt[8:0]};
            mem_wval = `FMI_ERASED;
        end else if (state == ST_MASS) begin
            mem_we = 1'b1;
            mem_widx = erase_cnt;
            mem_wval = `FMI_ERASED;
        end else if (byte_wr) begin
            mem_we = 1'b1;
            mem_wval = mem[prog_idx] & mem_wdata;
        end
    end

    always @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_widx] <= mem_wval;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path

    always @(posedge ref_clk) begin
        if (!rstn) begin
            mem_rdata <= 8'h00;
            mem_rvalid <= 1'b0;
        end else begin
            mem_rvalid <= mem_rd && !mem_busy;
            if (mem_rd && !mem_busy) begin
                if (info_hit) begin
                    mem_rdata <= rom_data;
                end else begin
                    mem_rdata <= mem[prog_idx];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // trim holding registers, shadow of the information area

    always @(posedge ref_clk) begin
        if (!rstn) begin
            trim_load <= 4'h0;
        end else if (!trim_load[3]) begin
            trim_load <= trim_load + 4'h1;
        end
    end

    always @(posedge ref_clk) begin
        if (!trim_load[3]) begin
            trim_hold[trim_load[2:0]] <= rom_trim;
        end else if (mem_wr && trim_hit && !mem_busy) begin
            trim_hold[mem_addr[2:0]] <= mem_wdata;
        end
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            trim_rdata <= 8'h00;
        end else begin
            trim_rdata <= trim_hold[trim_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // option outputs

    always @(posedge ref_clk) begin
        if (!rstn) begin
            option_bits <= 16'hFFFF;
            data_wr_block <= 1'b0;
        end else begin
            option_bits <= {mem[`FMI_OPT_HI], mem[`FMI_OPT_LO]};
            data_wr_block <= rom_wr_block;
        end
    end

    // information area has no write path at all: holds by design
    // contents live in the lookup of fmi_info_rom

endmodule
`default_nettype wire

// [sim/fmi_flash_map_chk.sv]
/*
 * Port assertions for the flash map and overlay block.
 * Assumes one clock domain and the synchronous active-low reset.
 */
`default_nettype none
module fmi_flash_map_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // requests
    input wire logic mem_rd,
    input wire logic ctl_wr,
    input wire logic pgsel_wr,
    input wire logic [7:0] reg_wdata,
    // responses
    input wire logic mem_rvalid,
    input wire logic mem_busy,
    input wire logic unlocked,
    input wire logic [2:0] erase_row,
    input wire logic [7:0] sect_protect
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] busy_len;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    // length of the running erase
    always @(posedge ref_clk) begin
        if (!mem_busy)
            busy_len <= 14'h0000;
        else
            busy_len <= busy_len + 14'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    a_rd_answer: assert property (mem_rd && !mem_busy |=> mem_rvalid)
        else $error("read not answered");
    a_rd_cause: assert property (mem_rvalid |->
        $past(mem_rd) && !$past(mem_busy)) else $error("stray read answer");
    a_busy_refuse: assert property (
        mem_busy && mem_rd |=> !mem_rvalid)
        else $error("read taken while busy");
    a_erase_len: assert property ($fell(mem_busy) |->
        busy_len == 14'h0200 || busy_len == 14'h1000
        || busy_len == 14'h2000) else $error("erase length wrong");
    a_erase_cause: assert property ($rose(mem_busy) |-> $past(ctl_wr)
        && $past(unlocked) && ($past(reg_wdata) == 8'h95
        || $past(reg_wdata) == 8'h63)) else $error("erase without command");
    a_row_step: assert property (mem_busy && $past(mem_busy)
        && $changed(erase_row) |-> erase_row == $past(erase_row) + 3'h1)
        else $error("erase row skipped");
    a_open_cause: assert property ($rose(unlocked) |->
        $past(pgsel_wr) || $past(mem_busy)) else $error("opened unasked");
    a_relock_other: assert property (ctl_wr && unlocked && !mem_busy
        && reg_wdata != 8'h95 && reg_wdata != 8'h63 |=> !unlocked)
        else $error("stayed open");
    a_prot_keep: assert property ($past(rstn) |->
        ($past(sect_protect) & ~sect_protect) == 8'h00)
        else $error("protect bit cleared");
    c_erase: cover property ($fell(mem_busy));
    c_read: cover property (mem_rvalid);
    c_open: cover property ($rose(unlocked));
    c_protect: cover property ($changed(sect_protect));
endmodule

bind fmi_flash_map fmi_flash_map_chk i_chk (.ref_clk(ref_clk), .rstn(rstn),
    .mem_rd(mem_rd), .ctl_wr(ctl_wr), .pgsel_wr(pgsel_wr),
    .reg_wdata(reg_wdata), .mem_rvalid(mem_rvalid), .mem_busy(mem_busy),
    .unlocked(unlocked), .erase_row(erase_row), .sect_protect(sect_protect));
`default_nettype wire

// [sim/fmi_core_model.sv]
/*
 * Core and debugger request model: one strobe for one cycle per call.
 * Assumes a single calling process.
 */
`default_nettype none
module fmi_core_model (
    // clock
    input wire logic ref_clk,
    // requests
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic ctl_wr,
    output logic pgsel_wr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {mem_addr, mem_rd, mem_wr, mem_wdata} = 26'h0;
        {ctl_wr, pgsel_wr, reg_wdata} = 10'h0;
    end
    // kind 0 read, 1 write, 2 control, 3 page select
    task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        mem_addr <= a;
        mem_wdata <= d;
        reg_wdata <= d;
        {mem_rd, mem_wr, ctl_wr, pgsel_wr} <= 4'h8 >> k;
        @(posedge ref_clk);
        {mem_rd, mem_wr, ctl_wr, pgsel_wr} <= 4'h0;
        // released lines do not keep their last value
        mem_addr <= ~a;
        mem_wdata <= ~d;
        reg_wdata <= ~d;
    endtask
    // page select, two keys, same page select again
    task automatic unlock(input logic [7:0] p);
        // relock first: an open controller would take 73 as a lock command
        op(2, 16'h0000, 8'h00);
        op(3, 16'h0000, p);
        op(2, 16'h0000, 8'h73);
        op(2, 16'h0000, 8'h8C);
        op(3, 16'h0000, p);
    endtask
endmodule
`default_nettype wire

// [sim/fmi_flash_map_bench.sv]
/*
 * Self-checking bench for the flash map and information overlay.
 * Assumes the core model drives every request strobe.
 */
`default_nettype none
module fmi_flash_map_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rstn, big_variant, mem_rd, mem_wr, ctl_wr, pgsel_wr;
    logic mem_rvalid, mem_busy, unlocked, data_wr_block;
    logic [15:0] mem_addr, option_bits;
    logic [7:0] mem_wdata, reg_wdata, mem_rdata, pgsel_value;
    logic [7:0] sect_protect, trim_rdata, d, t;
    logic [2:0] trim_sel, erase_row;
    logic dbg_access;
    logic [7:0] exp_q[$];
    int failures = 0;
    int n_tests = 0;
    int n;

    fmi_flash_map i_dut (.ref_clk(ref_clk), .rstn(rstn),
        .big_variant(big_variant), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .dbg_access(dbg_access),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_busy(mem_busy),
        .ctl_wr(ctl_wr), .pgsel_wr(pgsel_wr), .reg_wdata(reg_wdata),
        .pgsel_value(pgsel_value), .sect_protect(sect_protect),
        .unlocked(unlocked), .erase_row(erase_row), .trim_sel(trim_sel),
        .trim_rdata(trim_rdata), .option_bits(option_bits),
        .data_wr_block(data_wr_block));
    fmi_core_model i_core (.ref_clk(ref_clk), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .ctl_wr(ctl_wr), .pgsel_wr(pgsel_wr), .reg_wdata(reg_wdata));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_core.op(0, a, 8'h00);
    endtask
    task automatic erase_wait(input int len);
        n = 0;
        repeat (len) begin
            #1;
            if (mem_busy === 1'b1)
                n++;
            @(posedge ref_clk);
        end
    endtask
    function automatic logic [7:0] exp_info(input int a);
        string id;
        id = "FMI-DEMO-ID";
        if (a == 0)
            return 8'hFE;
        if (a < 8'h40)
            return 8'hFF;
        if (a < 8'h40 + id.len())
            return id[a - 8'h40];
        if (a < 8'h54)
            return 8'h0F;
        if (a < 8'h60)
            return 8'h00;
        return 8'h80;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // read answers are matched against the oldest note
    always @(posedge ref_clk) begin
        if (mem_rvalid === 1'b1 && exp_q.size() == 0)
            chk({8'h00, mem_rdata}, 16'hFFFF);
        else if (mem_rvalid === 1'b1)
            chk({8'h00, mem_rdata}, exp_q.pop_front());
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        failures++;
        results;
    end
    initial begin
        void'($urandom(32'h26306004));
        rstn = 1'b0;
        big_variant = 1'b1;
        dbg_access = 1'b0;
        trim_sel = 3'h0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        chk(data_wr_block, 1'b1);
        chk(trim_rdata, 8'hFE);
        i_core.op(2, 16'h0000, 8'h95);
        #1 chk(mem_busy, 1'b0);
        i_core.unlock(8'h00);
        i_core.op(2, 16'h0000, 8'h95);
        erase_wait(600);
        chk(16'(n), 16'h0200);
        d = 8'($urandom);
        t = 8'($urandom);
        i_core.op(1, 16'h0000, d);
        i_core.op(1, 16'h0001, t);
        repeat (2) @(posedge ref_clk);
        #1 chk(option_bits, {t, d});
        i_core.unlock(8'h0F);
        i_core.op(2, 16'h0000, 8'h95);
        // refused read in mid-erase
        i_core.op(0, 16'h1E00, 8'h00);
        erase_wait(600);
        chk(16'(n), 16'h01FE);
        chk(unlocked, 1'b1);
        i_core.op(1, 16'h1E10, d);
        i_core.op(1, 16'h1FFF, t);
        rd(16'h1FFF, t);
        rd(16'hFE10, d);
        i_core.op(2, 16'h0000, 8'h00);
        #1 chk(unlocked, 1'b0);
        i_core.op(3, 16'h0000, 8'h80);
        #1 chk(pgsel_value, 8'h80);
        for (int a = 0; a < 128; a++)
            rd(16'hFE00 + 16'(a), exp_info(a));
        i_core.op(1, 16'hFE10, 8'h00);
        rd(16'hFE10, 8'hFF);
        t = 8'($urandom);
        i_core.op(1, 16'hFE03, t);
        @(posedge ref_clk) trim_sel <= 3'h3;
        repeat (2) @(posedge ref_clk);
        #1 chk(trim_rdata, t);
        rd(16'hFE03, 8'hFF);
        i_core.op(3, 16'h0000, 8'h00);
        rd(16'hFE10, d);
        repeat (3) @(posedge ref_clk);
        #1 chk(trim_rdata, t);
        // mass erase is refused from user code, taken from debug
        i_core.unlock(8'h02);
        i_core.op(2, 16'h0000, 8'h63);
        #1 chk(unlocked, 1'b0);
        chk(mem_busy, 1'b0);
        i_core.unlock(8'h02);
        dbg_access <= 1'b1;
        i_core.op(2, 16'h0000, 8'h63);
        erase_wait(8300);
        dbg_access <= 1'b0;
        chk(16'(n), 16'h2000);
        rd(16'h1E10, 8'hFF);
        repeat (2) @(posedge ref_clk);
        #1 chk(option_bits, 16'hFFFF);
        // protect sector 7, pages 14 and 15 of the large part
        i_core.op(2, 16'h0000, 8'h00);
        i_core.op(2, 16'h0000, 8'h5E);
        i_core.op(3, 16'h0000, 8'h80);
        #1 chk(sect_protect, 8'h80);
        i_core.unlock(8'h0E);
        i_core.op(2, 16'h0000, 8'h95);
        #1 chk(mem_busy, 1'b0);
        chk(unlocked, 1'b0);
        i_core.unlock(8'h0D);
        i_core.op(2, 16'h0000, 8'h95);
        erase_wait(600);
        chk(16'(n), 16'h0200);
        chk(erase_row, 3'h7);
        // mark a cell of page 7, then restart as the small part
        i_core.unlock(8'h07);
        i_core.op(1, 16'h0E10, 8'h3C);
        rstn <= 1'b0;
        big_variant <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 chk(unlocked, 1'b0);
        chk(sect_protect, 8'h00);
        chk(trim_rdata, 8'hFF);
        rd(16'h1E10, 8'h3C);
        repeat (3) @(posedge ref_clk);
        chk(16'(exp_q.size()), 16'h0000);
        results;
    end
endmodule
`default_nettype wire
